// File: rtl/infrared_serial_link_control.sv
// APB-controlled infrared serial port with transceiver power and pin routing
//
// What this block does
// - power-down line low enables, high disables transceiver
// - power-down, transmit outputs; receive input; digital only
// - receive select 0x05, transmit select 0x04
// - infrared encoding on, 9600 baud, both directions
`timescale 1ns/1ps
module infrared_serial_link_control
    import ir_link_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        infrared_receive_line_in,
    output logic             infrared_transmit_line_out,
    output logic             infrared_transmit_line_oe_out,
    output logic             transceiver_power_down_pin_out,
    output logic             transceiver_power_down_pin_oe_out
);
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [3:0]  rx_sel;
        logic [3:0]  tx_sel;
        logic [15:0] div;
        logic [15:0] div_cnt;
        logic        tick;
        logic        tx_start;
        logic [7:0]  tx_data;
        logic        rx_valid;
        logic        rx_ovr;
        logic        frerr;
        logic [7:0]  rx_data;
        logic        sync1;
        logic        sync2;
        logic [31:0] rdata;
        logic        pdown;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;
    logic        tx_busy;
    logic        tx_line;
    logic        rx_done;
    logic        rx_frerr;
    logic [7:0]  rx_byte;
    logic        rx_routed;
    logic        tx_routed;
    logic        setup_wr;
    logic        setup_rd;
    logic        mapped;

    ////////////////////////////////////////////////////////////////////////////
    assign rx_routed = (st_r.rx_sel == RX_SELECT_CODE);
    assign tx_routed = (st_r.tx_sel == TX_SELECT_CODE);
    assign mapped    = (paddr_in == CTRL_OFS) || (paddr_in == STATUS_OFS) || (paddr_in == TXDATA_OFS) ||
                       (paddr_in == RXDATA_OFS) || (paddr_in == ROUTE_OFS) || (paddr_in == BAUDDIV_OFS);
    // writes act in the access cycle, read data is latched in setup; every access completes in one
    assign setup_wr  = psel_in && penable_in && pwrite_in;
    assign setup_rd  = psel_in && !penable_in && !pwrite_in;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.tx_start = 1'b0;
        st_nxt.sync1    = infrared_receive_line_in;
        st_nxt.sync2    = st_r.sync1;
        st_nxt.pdown    = st_r.ctrl[CTRL_PDOWN_BIT];
        // sub-bit tick at sixteen times the baud rate
        st_nxt.tick     = 1'b0;
        if (st_r.div_cnt == 16'h0000) begin
            st_nxt.div_cnt = st_r.div - 16'h0001;
            st_nxt.tick    = 1'b1;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt - 16'h0001;
        end
        // read data latched in setup so it is stable in the access cycle
        if (setup_rd) begin
            st_nxt.rdata = 32'h0000_0000;
            unique case (paddr_in)
                CTRL_OFS:    st_nxt.rdata = {28'h0, st_r.ctrl};
                STATUS_OFS:  st_nxt.rdata = {27'h0, rx_routed && tx_routed, st_r.frerr, st_r.rx_ovr,
                                             st_r.rx_valid, tx_busy | st_r.tx_start};
                TXDATA_OFS:  st_nxt.rdata = {24'h0, st_r.tx_data};
                RXDATA_OFS:  st_nxt.rdata = {24'h0, st_r.rx_data};
                ROUTE_OFS:   st_nxt.rdata = {24'h0, st_r.tx_sel, st_r.rx_sel};
                BAUDDIV_OFS: st_nxt.rdata = {16'h0, st_r.div};
                default:     st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // reading received data clears valid; status read clears error flags
        if (psel_in && penable_in && !pwrite_in) begin
            if (paddr_in == RXDATA_OFS) begin
                st_nxt.rx_valid = 1'b0;
            end
            if (paddr_in == STATUS_OFS) begin
                st_nxt.rx_ovr = 1'b0;
                st_nxt.frerr  = 1'b0;
            end
        end
        if (setup_wr) begin
            unique case (paddr_in)
                CTRL_OFS:    st_nxt.ctrl = pwdata_in[3:0];
                TXDATA_OFS: begin
                    st_nxt.tx_data = pwdata_in[7:0];
                    // a write while busy starts no frame but still updates tx_data, software polls busy first
                    st_nxt.tx_start = st_r.ctrl[CTRL_TXEN_BIT] && !tx_busy && !st_r.tx_start;
                end
                ROUTE_OFS: begin
                    st_nxt.rx_sel = pwdata_in[3:0];
                    st_nxt.tx_sel = pwdata_in[7:4];
                end
                BAUDDIV_OFS: st_nxt.div = (pwdata_in[15:0] == 16'h0000) ? 16'h0001 : pwdata_in[15:0];
                default: ;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (rx_done && st_r.ctrl[CTRL_RXEN_BIT] && rx_routed) begin
            st_nxt.rx_ovr   = st_r.rx_valid | st_nxt.rx_ovr;
            st_nxt.rx_valid = 1'b1;
            st_nxt.rx_data  = rx_byte;
            st_nxt.frerr    = rx_frerr | st_nxt.frerr;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r        <= '0;
            st_r.ctrl   <= CTRL_RESET;
            st_r.rx_sel <= RXSEL_RESET;
            st_r.tx_sel <= TXSEL_RESET;
            st_r.div    <= BAUDDIV_RESET;
            st_r.pdown  <= CTRL_RESET[CTRL_PDOWN_BIT];
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ir_pulse_tx u_tx (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .tick_in    (st_r.tick),
        .infrared_encoding_enable_in    (st_r.ctrl[CTRL_INFRARED_ENCODING_ENABLE_BIT]),
        .start_in   (st_r.tx_start),
        .data_in    (st_r.tx_data),
        .busy_out   (tx_busy),
        .line_out   (tx_line)
    );

    // the receiver only sees the pin once routed and enabled, idle otherwise;
    // a frame half heard while off would otherwise swallow the next real start bit
    ir_pulse_rx u_rx (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .tick_in    (st_r.tick),
        .infrared_encoding_enable_in    (st_r.ctrl[CTRL_INFRARED_ENCODING_ENABLE_BIT]),
        .line_in    ((rx_routed && st_r.ctrl[CTRL_RXEN_BIT]) ? st_r.sync2 : !st_r.ctrl[CTRL_INFRARED_ENCODING_ENABLE_BIT]),
        .done_out   (rx_done),
        .frerr_out  (rx_frerr),
        .data_out   (rx_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign prdata_out                        = st_r.rdata;
    assign pready_out                        = 1'b1;
    assign pslverr_out                       = psel_in && penable_in && !mapped;
    // unrouted transmit pin stays dark so the far LED is not lit
    assign infrared_transmit_line_out        = tx_routed && tx_line;
    assign infrared_transmit_line_oe_out     = 1'b1;
    assign transceiver_power_down_pin_out    = st_r.pdown;
    assign transceiver_power_down_pin_oe_out = 1'b1;
endmodule // infrared_serial_link_control

// File: rtl/ir_link_pkg.sv
// constants shared by the infrared serial link control block
package ir_link_pkg;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;
    localparam logic [11:0] TXDATA_OFS     = 12'h008;
    localparam logic [11:0] RXDATA_OFS     = 12'h00C;
    localparam logic [11:0] ROUTE_OFS      = 12'h010;
    localparam logic [11:0] BAUDDIV_OFS    = 12'h014;
    // control field positions
    localparam int CTRL_PDOWN_BIT          = 0;
    localparam int CTRL_INFRARED_ENCODING_ENABLE_BIT           = 1;
    localparam int CTRL_TXEN_BIT           = 2;
    localparam int CTRL_RXEN_BIT           = 3;
    // status field positions
    localparam int STAT_TXBUSY_BIT         = 0;
    localparam int STAT_RXVALID_BIT        = 1;
    localparam int STAT_RXOVR_BIT          = 2;
    localparam int STAT_FRERR_BIT          = 3;
    localparam int STAT_ROUTED_BIT         = 4;
    // pin routing selector codes
    localparam logic [3:0] RX_SELECT_CODE  = 4'h5;
    localparam logic [3:0] TX_SELECT_CODE  = 4'h4;
    // reset values
    localparam logic [3:0] CTRL_RESET      = 4'h1;
    localparam logic [3:0] RXSEL_RESET     = 4'h0;
    localparam logic [3:0] TXSEL_RESET     = 4'h0;
    // timing: 20 MHz clock, 9600 baud, 16 sub-ticks per bit
    localparam int CLK_HZ                  = 20000000;
    localparam int BAUD_RATE               = 9600;
    localparam int OVERSAMPLE              = 16;
    localparam int BAUD_DIV                = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
    localparam logic [15:0] BAUDDIV_RESET  = 16'(BAUD_DIV);
    localparam int PULSE_TICKS             = 3;
    localparam int DATA_BITS               = 8;
endpackage : ir_link_pkg

// File: rtl/ir_pulse_tx.sv
// infrared-encoding transmit serialiser
`timescale 1ns/1ps
module ir_pulse_tx
    import ir_link_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       tick_in,
    input  wire logic       infrared_encoding_enable_in,
    input  wire logic       start_in,
    input  wire logic [7:0] data_in,
    output logic            busy_out,
    output logic            line_out
);
    typedef struct packed {
        logic       busy;
        logic [3:0] bit_idx;
        logic [3:0] sub;
        logic [9:0] frame;
        logic       line;
    } tx_state_t;

    tx_state_t st_r;
    tx_state_t st_nxt;
    logic      cur_bit;
    // lead-in slot before the start bit: the frame waits for a tick so every pulse is whole ticks long
    localparam logic [3:0] PRE_BIT = 4'hF;

    always_comb begin
        st_nxt  = st_r;
        cur_bit = st_r.frame[0];
        if (!st_r.busy) begin
            if (start_in) begin
                st_nxt.busy    = 1'b1;
                st_nxt.frame   = {1'b1, data_in, 1'b0};
                st_nxt.bit_idx = PRE_BIT;
                st_nxt.sub     = 4'(OVERSAMPLE - 1);
            end
        end else if (tick_in) begin
            st_nxt.sub = st_r.sub + 4'h1;
            if (st_r.sub == 4'(OVERSAMPLE - 1)) begin
                if (st_r.bit_idx != PRE_BIT) begin
                    st_nxt.frame = {1'b1, st_r.frame[9:1]};
                end
                if (st_r.bit_idx == 4'(DATA_BITS + 1)) begin
                    st_nxt.busy = 1'b0;
                end
                st_nxt.bit_idx = st_r.bit_idx + 4'h1;
            end
        end
        // in infrared mode a zero bit is a short light pulse, one bit is dark
        if (!st_r.busy) begin
            st_nxt.line = infrared_encoding_enable_in ? 1'b0 : 1'b1;
        end else if (infrared_encoding_enable_in) begin
            st_nxt.line = (st_r.bit_idx != PRE_BIT) && !cur_bit && (st_r.sub < 4'(PULSE_TICKS));
        end else begin
            st_nxt.line = (st_r.bit_idx == PRE_BIT) || cur_bit;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign busy_out = st_r.busy;
    assign line_out = st_r.line;
endmodule // ir_pulse_tx

// File: rtl/ir_pulse_rx.sv
// infrared-encoding receive deserialiser
`timescale 1ns/1ps
module ir_pulse_rx
    import ir_link_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       tick_in,
    input  wire logic       infrared_encoding_enable_in,
    input  wire logic       line_in,
    output logic            done_out,
    output logic            frerr_out,
    output logic [7:0]      data_out
);
    typedef struct packed {
        logic       busy;
        logic [3:0] bit_idx;
        logic [3:0] sub;
        logic       seen;
        logic [7:0] shift;
        logic       done;
        logic       frerr;
        logic [7:0] data;
    } rx_state_t;

    rx_state_t st_r;
    rx_state_t st_nxt;
    logic      mark;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.done  = 1'b0;
        // in infrared mode a light pulse marks a zero bit
        mark = infrared_encoding_enable_in ? line_in : !line_in;
        if (!st_r.busy) begin
            if (tick_in && mark) begin
                st_nxt.busy    = 1'b1;
                st_nxt.bit_idx = 4'h0;
                st_nxt.sub     = 4'h1;
                st_nxt.seen    = 1'b1;
            end
        end else if (tick_in) begin
            st_nxt.sub  = st_r.sub + 4'h1;
            st_nxt.seen = st_r.seen | mark;
            if (st_r.sub == 4'(OVERSAMPLE - 1)) begin
                st_nxt.sub     = 4'h0;
                st_nxt.seen    = 1'b0;
                st_nxt.bit_idx = st_r.bit_idx + 4'h1;
                if (st_r.bit_idx >= 4'h1 && st_r.bit_idx <= 4'(DATA_BITS)) begin
                    st_nxt.shift = {!(st_r.seen | mark), st_r.shift[7:1]};
                end
                if (st_r.bit_idx == 4'(DATA_BITS + 1)) begin
                    st_nxt.busy  = 1'b0;
                    st_nxt.done  = 1'b1;
                    st_nxt.data  = st_r.shift;
                    st_nxt.frerr = st_r.seen | mark;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign done_out  = st_r.done;
    assign frerr_out = st_r.frerr;
    assign data_out  = st_r.data;
endmodule // ir_pulse_rx

// File: tb/ir_link_monitor.sv
// assertion checker for the infrared serial link control block
`timescale 1ns/1ps
module ir_link_monitor
    import ir_link_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        ce_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        infrared_receive_line_in,
    input wire logic        infrared_transmit_line_out,
    input wire logic        infrared_transmit_line_oe_out,
    input wire logic        transceiver_power_down_pin_out,
    input wire logic        transceiver_power_down_pin_oe_out
);
    logic w_ctrl;
    logic pd_want_r;
    assign w_ctrl = psel_in && penable_in && pwrite_in && (paddr_in == CTRL_OFS);
    always_ff @(posedge clk_sys_in) begin
        if (w_ctrl) begin
            pd_want_r <= pwdata_in[CTRL_PDOWN_BIT];
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////
    ready_oe_high_a: assert property (pready_out && infrared_transmit_line_oe_out
        && transceiver_power_down_pin_oe_out) else $error("ready or drive enable low");
    err_in_access_a: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error outside access phase");
    unmapped_read_a: assert property (psel_in && penable_in && !pwrite_in && paddr_in > BAUDDIV_OFS
        |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped read not refused");
    mapped_ok_a: assert property (psel_in && penable_in && paddr_in <= BAUDDIV_OFS
        && paddr_in[1:0] == 2'h0 |-> !pslverr_out) else $error("mapped access refused");
    reset_pins_a: assert property (disable iff (1'b0) rst_in
        |=> transceiver_power_down_pin_out && !infrared_transmit_line_out) else $error("pins wrong in reset");
    pdown_follow_a: assert property (w_ctrl |-> ##2 transceiver_power_down_pin_out == pd_want_r)
        else $error("power-down pin does not follow control write");
    pdown_quiet_a: assert property (!$stable(transceiver_power_down_pin_out) |-> $past(w_ctrl)
        || $past(w_ctrl, 2) || $past(rst_in) || $past(rst_in, 2)) else $error("power-down pin moved alone");
    pulse_min_a: assert property ($rose(infrared_transmit_line_out)
        |-> infrared_transmit_line_out [*3]) else $error("transmit pulse too short");
endmodule // ir_link_monitor

bind infrared_serial_link_control ir_link_monitor u_mon (.clk_sys_in, .rst_in, .ce_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .infrared_receive_line_in,
    .infrared_transmit_line_out, .infrared_transmit_line_oe_out, .transceiver_power_down_pin_out,
    .transceiver_power_down_pin_oe_out);

// File: tb/ir_transceiver_model.sv
// behavioural infrared transceiver: LED, photodiode and shutdown input
`timescale 1ns/1ps
module ir_transceiver_model (
    input  wire logic clk_sys_in,
    input  wire logic clr_in,
    input  wire logic shutdown_in,
    input  wire logic led_in,
    output logic      photo_out,
    output int        pulses_out,
    output int        lit_out
);
    logic led_d;
    // light from our own LED reflects onto the photodiode; silent while shut down
    assign photo_out = !shutdown_in && led_in;
    always @(posedge clk_sys_in) begin
        led_d <= led_in;
        if (clr_in) begin
            pulses_out <= 0;
            lit_out <= 0;
        end else if (!shutdown_in) begin
            if (led_in) lit_out <= lit_out + 1;
            if (led_in && !led_d) pulses_out <= pulses_out + 1;
        end
    end
endmodule // ir_transceiver_model

// File: tb/testbench.sv
// self-checking bench for the infrared serial link control block
`timescale 1ns/1ps
module testbench;
    import ir_link_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out, pslverr_out, rx_line, tx_line, tx_oe, pd_pin, pd_oe;
    logic        clr = 1'b1;
    logic [31:0] q;
    logic        e;
    int          pulses, lit;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;
    infrared_serial_link_control DUT (.clk_sys_in, .rst_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .infrared_receive_line_in(rx_line),
        .infrared_transmit_line_out(tx_line), .infrared_transmit_line_oe_out(tx_oe),
        .transceiver_power_down_pin_out(pd_pin), .transceiver_power_down_pin_oe_out(pd_oe));
    ir_transceiver_model u_far (.clk_sys_in, .clr_in(clr), .shutdown_in(pd_pin), .led_in(tx_line),
        .photo_out(rx_line), .pulses_out(pulses), .lit_out(lit));
    initial forever #25 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1) @(posedge clk_sys_in);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // polls status; a miss shows up in the comparisons that follow
    task wait_status(input logic [31:0] mask, input logic [31:0] val);
        int n;
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0);
            n++;
        end while ((q & mask) !== val && n < 400);
    endtask
    task clear_counts;
        @(posedge clk_sys_in);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(CTRL_OFS, 32'h1);
        rd(ROUTE_OFS, 32'h0);
        rd(BAUDDIV_OFS, 32'h82);
        rd(STATUS_OFS, 32'h0);
        check(tx_oe, 32'h1);
        check(pd_oe, 32'h1);
        rd(12'h018, 32'h0);
        check(e, 32'h1);
        wr(12'h01C, 32'hFF);
        check(e, 32'h1);
        // short divisor keeps a frame at 320 clocks
        wr(BAUDDIV_OFS, 32'h2);
        rd(BAUDDIV_OFS, 32'h2);
        wr(ROUTE_OFS, 32'h45);
        rd(ROUTE_OFS, 32'h45);
        rd(STATUS_OFS, 32'h10);
        wr(CTRL_OFS, 32'hE);
        rd(CTRL_OFS, 32'hE);
        check(pd_pin, 32'h0);
        check(tx_line, 32'h0);
        clear_counts();
        wr(TXDATA_OFS, 32'h55);
        wait_status(32'h3, 32'h2);
        check(pulses, 32'h5);
        check(lit, 32'h1E);
        rd(RXDATA_OFS, 32'h55);
        rd(STATUS_OFS, 32'h10);
        wr(TXDATA_OFS, 32'h0F);
        wait_status(32'h3, 32'h2);
        wr(TXDATA_OFS, 32'hF0);
        wait_status(32'h5, 32'h4);
        // the poll that saw the overrun already cleared it, so its own value is the one to judge
        check(q, 32'h16);
        rd(STATUS_OFS, 32'h12);
        apb(1'b0, RXDATA_OFS, 32'h0);
        wr(ROUTE_OFS, 32'h44);
        clear_counts();
        wr(TXDATA_OFS, 32'h00);
        wait_status(32'h1, 32'h0);
        check(pulses, 32'h9);
        rd(STATUS_OFS, 32'h0);
        wr(ROUTE_OFS, 32'h45);
        wr(CTRL_OFS, 32'hC);
        rd(CTRL_OFS, 32'hC);
        check(tx_line, 32'h1);
        // an unrouted transmit pin must stay dark
        wr(ROUTE_OFS, 32'h05);
        rd(ROUTE_OFS, 32'h05);
        check(tx_line, 32'h0);
        wr(CTRL_OFS, 32'hD);
        rd(CTRL_OFS, 32'hD);
        check(pd_pin, 32'h1);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(CTRL_OFS, 32'h1);
        rd(ROUTE_OFS, 32'h0);
        check(pd_pin, 32'h1);
        report_and_stop();
    end
endmodule // testbench
